// ==== nand_host_defs.svh ====
// Constants for the NAND unique-ID and feature host controller
`ifndef NAND_HOST_DEFS_SVH
`define NAND_HOST_DEFS_SVH

// Timing, in ns, then in cycles of CLK_I
`define CLK_PERIOD_NS         4
`define NS2CYC(ns)            (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_NS             25
`define BUSY_ONSET_NS         100
`define ADDR_TO_DATA_LOAD_NS  200
`define STROBE_CYC            `NS2CYC(`STROBE_NS)
`define READ_LOW_CYC          (`NS2CYC(`STROBE_NS) + 3)
`define BUSY_ONSET_CYC        `NS2CYC(`BUSY_ONSET_NS)
`define ADL_CYC               `NS2CYC(`ADDR_TO_DATA_LOAD_NS)

// Device command and address bytes
`define CMD_UID               8'hed
`define CMD_SET_FEAT          8'hef
`define CMD_GET_FEAT          8'hee
`define CMD_STATUS            8'h70
`define CMD_READ_MODE         8'h00
`define CMD_RND_READ          8'h05
`define CMD_RND_CONFIRM       8'he0
`define ADDR_UID              8'h00

// Feature addresses and fields
`define FA_TIMING             8'h01
`define FA_DRIVE              8'h80
`define FA_RB_PULL            8'h81
`define FA_ARRAY_MODE         8'h90
`define TIMING_MODE_MAX       8'h05
`define ARRAY_ECC_BIT         3
`define STAT_READY_BIT        6

// Unique-ID layout
`define UID_COPY_BYTES        32
`define UID_HALF_BYTES        16

// Register byte offsets
`define R_CTRL                8'h00
`define R_FADDR               8'h04
`define R_PARAM               8'h08
`define R_COPY                8'h0c
`define R_STAT                8'h10
`define R_GETDATA             8'h14
`define R_BUF_BASE            8'h80

// Field positions
`define CTRL_OP_LSB           0
`define CTRL_POLL_BIT         3
`define STAT_BUSY_BIT         0
`define STAT_DONE_BIT         1
`define STAT_UIDOK_BIT        2
`define STAT_REFUSED_BIT      3
`define STAT_BYTE_LSB         8

`endif

// ==== nand_host_pkg.sv ====
// Types for the NAND unique-ID and feature host controller
package nand_host_pkg;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_UID  = 3'h1,
    OP_SET  = 3'h2,
    OP_GET  = 3'h3,
    OP_STAT = 3'h4
  } op_t;

  typedef enum logic [3:0] {
    K_END  = 4'h0,
    K_CMD  = 4'h1,
    K_ADDR = 4'h2,
    K_WR   = 4'h3,
    K_RD   = 4'h4,
    K_STAT = 4'h5,
    K_BUSY = 4'h6,
    K_DLY  = 4'h7,
    K_P70  = 4'h8,
    K_PST  = 4'h9,
    K_P00  = 4'ha
  } kind_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_PRE  = 3'b001,
    S_NEXT = 3'b011,
    S_LOW  = 3'b010,
    S_HIGH = 3'b110,
    S_WAIT = 3'b111,
    S_DONE = 3'b101
  } state_t;

  typedef struct packed {
    kind_t      kind;
    logic [7:0] data;
    logic [4:0] last;
  } act_t;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
  } pins_t;

endpackage

// ==== byte_buf.sv ====
// Small byte memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module byte_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock
  input  wire logic                     clk_i,
  // Write port
  input  wire logic                     we_i,
  input  wire logic [$clog2(DEPTH)-1:0] wa_i,
  input  wire logic [WIDTH-1:0]         wd_i,
  // Read port
  input  wire logic [$clog2(DEPTH)-1:0] ra_i,
  output logic      [WIDTH-1:0]         rd_o
);
  if (WIDTH < 1 || DEPTH < 2) begin : g_bad_geometry
    $error("byte_buf: bad geometry");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[wa_i] <= wd_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rd_o <= mem[ra_i];
  end
endmodule // byte_buf
`default_nettype wire

// ==== nand_uid_feat_host.sv ====
// Host controller: NAND unique-ID read and feature set/get over Wishbone
// How it works
// - EDh, one 00h address, then wait busy
// - After status polling, send 00h before data
// - XOR halves; copy valid when all FFh
// - 05h/E0h moves output to chosen copy
// - ECC bit forced zero on fixed-ECC parts
// - Wait address-to-data load before parameters
// - One parameter per WE# rise, in order
`timescale 1ns/1ps
`default_nettype none
`include "nand_host_defs.svh"
module nand_uid_feat_host #(
  parameter int IO_W      = 8,
  parameter bit ECC_FIXED = 1'b0
) (
  // System
  input  wire logic              CLK_I,
  input  wire logic              RST_I,
  // Wishbone slave
  input  wire logic [7:0]        ADR_I,
  input  wire logic [31:0]       DAT_I,
  input  wire logic [3:0]        SEL_I,
  input  wire logic              WE_I,
  input  wire logic              STB_I,
  input  wire logic              CYC_I,
  output logic      [31:0]       DAT_O,
  output logic                   ACK_O,
  // NAND pins
  output logic                   CE_N_O,
  output logic                   CLE_O,
  output logic                   ALE_O,
  output logic                   WE_N_O,
  output logic                   RE_N_O,
  output logic      [IO_W-1:0]   IO_O,
  output logic                   IO_OE_O,
  input  wire logic [IO_W-1:0]   IO_I,
  input  wire logic              RB_I
);
  if (IO_W != 8 && IO_W != 16) begin : g_bad_width
    $error("nand_uid_feat_host: IO_W must be 8 or 16");
  end

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
    return old;
  endfunction

  function automatic logic fa_known(input logic [7:0] fa);
    return fa == `FA_TIMING || fa == `FA_DRIVE || fa == `FA_RB_PULL || fa == `FA_ARRAY_MODE;
  endfunction

  // Step table of each operation
  function automatic nand_host_pkg::act_t prog(input nand_host_pkg::op_t op,
                                               input logic [4:0] st, input logic [7:0] fa,
                                               input logic [3:0] copy);
    nand_host_pkg::act_t a;
    a = '{kind: nand_host_pkg::K_END, data: 8'h00, last: 5'h00};
    unique case (op)
      nand_host_pkg::OP_UID: begin
        case (st)
          5'h00: a = '{nand_host_pkg::K_CMD, `CMD_UID, 5'h00};
          5'h01: a = '{nand_host_pkg::K_ADDR, `ADDR_UID, 5'h00};
          5'h02: a = '{nand_host_pkg::K_BUSY, 8'h00, 5'h00};
          5'h03: a = '{nand_host_pkg::K_CMD, `CMD_RND_READ, 5'h00};
          5'h04: a = '{nand_host_pkg::K_ADDR, {copy[2:0], 5'h00}, 5'h00};
          5'h05: a = '{nand_host_pkg::K_ADDR, {7'h00, copy[3]}, 5'h00};
          5'h06: a = '{nand_host_pkg::K_CMD, `CMD_RND_CONFIRM, 5'h00};
          5'h07: a = '{nand_host_pkg::K_DLY, 8'h00, 5'h00};
          5'h08: a = '{nand_host_pkg::K_RD, 8'h00, 5'(`UID_COPY_BYTES - 1)};
          default: a = '{nand_host_pkg::K_END, 8'h00, 5'h00};
        endcase
      end
      nand_host_pkg::OP_SET: begin
        case (st)
          5'h00: a = '{nand_host_pkg::K_CMD, `CMD_SET_FEAT, 5'h00};
          5'h01: a = '{nand_host_pkg::K_ADDR, fa, 5'h00};
          5'h02: a = '{nand_host_pkg::K_DLY, 8'h00, 5'h00};
          5'h03: a = '{nand_host_pkg::K_WR, 8'h00, 5'h03};
          5'h04: a = '{nand_host_pkg::K_BUSY, 8'h00, 5'h00};
          5'h05: a = '{nand_host_pkg::K_CMD, `CMD_STATUS, 5'h00};
          5'h06: a = '{nand_host_pkg::K_STAT, 8'h00, 5'h00};
          default: a = '{nand_host_pkg::K_END, 8'h00, 5'h00};
        endcase
      end
      nand_host_pkg::OP_GET: begin
        case (st)
          5'h00: a = '{nand_host_pkg::K_CMD, `CMD_GET_FEAT, 5'h00};
          5'h01: a = '{nand_host_pkg::K_ADDR, fa, 5'h00};
          5'h02: a = '{nand_host_pkg::K_BUSY, 8'h00, 5'h00};
          5'h03: a = '{nand_host_pkg::K_RD, 8'h00, 5'h03};
          default: a = '{nand_host_pkg::K_END, 8'h00, 5'h00};
        endcase
      end
      nand_host_pkg::OP_STAT: begin
        case (st)
          5'h00: a = '{nand_host_pkg::K_CMD, `CMD_STATUS, 5'h00};
          5'h01: a = '{nand_host_pkg::K_STAT, 8'h00, 5'h00};
          default: a = '{nand_host_pkg::K_END, 8'h00, 5'h00};
        endcase
      end
      default: a = '{nand_host_pkg::K_END, 8'h00, 5'h00};
    endcase
    return a;
  endfunction

  // Registers and engine state
  nand_host_pkg::state_t state_r;
  nand_host_pkg::op_t    op_r;
  nand_host_pkg::kind_t  poll_k_r;
  nand_host_pkg::kind_t  kind;
  nand_host_pkg::act_t   act;
  nand_host_pkg::pins_t  pins_r;
  logic [7:0]  faddr_r;
  logic [31:0] param_r;
  logic [3:0]  copy_r;
  logic        poll_r;
  logic        done_r;
  logic        refused_r;
  logic        uid_ok_r;
  logic [7:0]  stat_byte_r;
  logic [31:0] getdata_r;
  logic [4:0]  step_r;
  logic [4:0]  cnt_r;
  logic [7:0]  tmr_r;
  logic [7:0]  rx;
  logic [7:0]  p1_eff;
  logic        ack_r;
  logic        pend_r;
  logic        rb_s1, rb_s2;
  logic [IO_W-1:0] io_s1, io_s2;
  logic [7:0]  mem_rd;
  logic        mem_we;
  logic        wr_ctrl;
  logic        start_ok;
  logic        low_end;

  assign act  = prog(op_r, step_r, faddr_r, copy_r);
  assign kind = (poll_k_r != nand_host_pkg::K_END) ? poll_k_r : act.kind;
  assign rx   = io_s2[7:0];
  // Fixed-ECC parts get bit 3 of the array-mode parameter forced low
  assign p1_eff = (faddr_r == `FA_ARRAY_MODE && ECC_FIXED) ?
                  (param_r[7:0] & ~(8'h01 << `ARRAY_ECC_BIT)) : param_r[7:0];
  assign low_end = (state_r == nand_host_pkg::S_LOW) && tmr_r == 8'h00;
  assign mem_we  = low_end && op_r == nand_host_pkg::OP_UID && kind == nand_host_pkg::K_RD;

  // Pin synchronisers
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rb_s1 <= 1'b0;
      rb_s2 <= 1'b0;
      io_s1 <= '0;
      io_s2 <= '0;
    end else begin
      rb_s1 <= RB_I;
      rb_s2 <= rb_s1;
      io_s1 <= IO_I;
      io_s2 <= io_s1;
    end
  end

  // Wishbone: ack two edges after the request, writes land on the ack edge
  assign wr_ctrl = pend_r && WE_I && ADR_I[7:2] == `R_CTRL >> 2 && SEL_I[0];
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pend_r <= 1'b0;
      ack_r  <= 1'b0;
    end else begin
      pend_r <= CYC_I && STB_I && !pend_r && !ack_r;
      ack_r  <= CYC_I && STB_I && pend_r;
    end
  end
  assign ACK_O = ack_r;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      DAT_O <= 32'h0000_0000;
    end else if (pend_r && !WE_I) begin
      if (ADR_I[7]) begin
        DAT_O <= {24'h00_0000, mem_rd};
      end else begin
        unique case ({ADR_I[6:2], 2'b00})
          7'(`R_CTRL):    DAT_O <= {28'h000_0000, poll_r, op_r};
          7'(`R_FADDR):   DAT_O <= {24'h00_0000, faddr_r};
          7'(`R_PARAM):   DAT_O <= param_r;
          7'(`R_COPY):    DAT_O <= {28'h000_0000, copy_r};
          7'(`R_STAT):    DAT_O <= {16'h0000, stat_byte_r, 4'h0, refused_r, uid_ok_r,
                                    done_r, state_r != nand_host_pkg::S_IDLE};
          7'(`R_GETDATA): DAT_O <= getdata_r;
          default:        DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Configuration registers
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      faddr_r <= 8'h00;
      param_r <= 32'h0000_0000;
      copy_r  <= 4'h0;
      poll_r  <= 1'b0;
    end else if (pend_r && WE_I && state_r == nand_host_pkg::S_IDLE) begin
      if (ADR_I[7:2] == `R_FADDR >> 2 && SEL_I[0]) faddr_r <= DAT_I[7:0];
      if (ADR_I[7:2] == `R_PARAM >> 2) param_r <= lane_merge(param_r, DAT_I, SEL_I);
      if (ADR_I[7:2] == `R_COPY >> 2 && SEL_I[0]) copy_r <= DAT_I[3:0];
      if (wr_ctrl) poll_r <= DAT_I[`CTRL_POLL_BIT];
    end
  end

  // Start check: unknown features and out-of-range values are refused
  always_comb begin
    unique case (nand_host_pkg::op_t'(DAT_I[2:0]))
      nand_host_pkg::OP_UID, nand_host_pkg::OP_STAT: start_ok = 1'b1;
      nand_host_pkg::OP_GET: start_ok = fa_known(faddr_r);
      nand_host_pkg::OP_SET: start_ok = fa_known(faddr_r) &&
        !(faddr_r == `FA_TIMING && param_r[7:0] > `TIMING_MODE_MAX) &&
        !(faddr_r == `FA_ARRAY_MODE && param_r[7:5] != 3'h0);
      default: start_ok = 1'b0;
    endcase
  end

  // Sequencer
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r   <= nand_host_pkg::S_IDLE;
      op_r      <= nand_host_pkg::OP_NONE;
      poll_k_r  <= nand_host_pkg::K_END;
      step_r    <= 5'h00;
      cnt_r     <= 5'h00;
      tmr_r     <= 8'h00;
      done_r    <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      unique case (state_r)
        nand_host_pkg::S_IDLE: begin
          if (wr_ctrl && DAT_I[2:0] != 3'h0) begin
            done_r    <= 1'b0;
            refused_r <= !start_ok;
            if (start_ok) begin
              op_r    <= nand_host_pkg::op_t'(DAT_I[2:0]);
              step_r  <= 5'h00;
              cnt_r   <= 5'h00;
              state_r <= nand_host_pkg::S_PRE;
            end
          end
        end
        nand_host_pkg::S_PRE: begin
          if (rb_s2) state_r <= nand_host_pkg::S_NEXT;
        end
        nand_host_pkg::S_NEXT: begin
          unique case (kind)
            nand_host_pkg::K_END:  state_r <= nand_host_pkg::S_DONE;
            nand_host_pkg::K_DLY: begin
              tmr_r   <= 8'(`ADL_CYC - 1);
              state_r <= nand_host_pkg::S_HIGH;
            end
            nand_host_pkg::K_BUSY: begin
              tmr_r   <= 8'(`BUSY_ONSET_CYC - 1);
              state_r <= nand_host_pkg::S_WAIT;
            end
            nand_host_pkg::K_RD, nand_host_pkg::K_STAT, nand_host_pkg::K_PST: begin
              tmr_r   <= 8'(`READ_LOW_CYC - 1);
              state_r <= nand_host_pkg::S_LOW;
            end
            default: begin
              tmr_r   <= 8'(`STROBE_CYC - 1);
              state_r <= nand_host_pkg::S_LOW;
            end
          endcase
        end
        nand_host_pkg::S_LOW: begin
          if (tmr_r != 8'h00) begin
            tmr_r <= tmr_r - 8'h01;
          end else begin
            tmr_r   <= 8'(`STROBE_CYC - 1);
            state_r <= nand_host_pkg::S_HIGH;
          end
        end
        nand_host_pkg::S_HIGH: begin
          if (tmr_r != 8'h00) begin
            tmr_r <= tmr_r - 8'h01;
          end else begin
            state_r <= nand_host_pkg::S_NEXT;
            if (poll_k_r == nand_host_pkg::K_P70) begin
              poll_k_r <= nand_host_pkg::K_PST;
            end else if (poll_k_r == nand_host_pkg::K_PST) begin
              if (stat_byte_r[`STAT_READY_BIT]) poll_k_r <= nand_host_pkg::K_P00;
            end else if (poll_k_r == nand_host_pkg::K_P00) begin
              poll_k_r <= nand_host_pkg::K_END;
              step_r   <= step_r + 5'h01;
            end else if ((kind == nand_host_pkg::K_WR || kind == nand_host_pkg::K_RD) &&
                         cnt_r != act.last) begin
              cnt_r <= cnt_r + 5'h01;
            end else begin
              cnt_r  <= 5'h00;
              step_r <= step_r + 5'h01;
            end
          end
        end
        nand_host_pkg::S_WAIT: begin
          // Device may hold R/B# low longer after a timing mode change
          if (tmr_r != 8'h00) begin
            tmr_r <= tmr_r - 8'h01;
          end else if (poll_r) begin
            poll_k_r <= nand_host_pkg::K_P70;
            state_r  <= nand_host_pkg::S_NEXT;
          end else if (rb_s2) begin
            step_r  <= step_r + 5'h01;
            state_r <= nand_host_pkg::S_NEXT;
          end
        end
        nand_host_pkg::S_DONE: begin
          done_r  <= 1'b1;
          op_r    <= nand_host_pkg::OP_NONE;
          state_r <= nand_host_pkg::S_IDLE;
        end
        default: state_r <= nand_host_pkg::S_IDLE;
      endcase
    end
  end

  // Captured read data and copy check
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      stat_byte_r <= 8'h00;
      getdata_r   <= 32'h0000_0000;
      uid_ok_r    <= 1'b0;
    end else if (state_r == nand_host_pkg::S_PRE && op_r == nand_host_pkg::OP_UID) begin
      uid_ok_r <= 1'b1;
    end else if (low_end) begin
      if (kind == nand_host_pkg::K_STAT || kind == nand_host_pkg::K_PST) begin
        stat_byte_r <= rx;
      end
      if (kind == nand_host_pkg::K_RD && op_r == nand_host_pkg::OP_GET) begin
        getdata_r[8*cnt_r[1:0] +: 8] <= rx;
      end
      if (mem_we && cnt_r >= 5'(`UID_HALF_BYTES) && (mem_rd ^ rx) != 8'hff) begin
        uid_ok_r <= 1'b0;
      end
    end
  end

  // Identifier buffer; while busy its read port serves the complement check
  byte_buf #(.WIDTH(8), .DEPTH(`UID_COPY_BYTES)) u_buf (
    .clk_i (CLK_I),
    .we_i  (mem_we),
    .wa_i  (cnt_r),
    .wd_i  (rx),
    .ra_i  (state_r == nand_host_pkg::S_IDLE ? ADR_I[6:2] : cnt_r - 5'(`UID_HALF_BYTES)),
    .rd_o  (mem_rd)
  );

  // Pin drive, one cycle behind the sequencer
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pins_r  <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1};
      IO_O    <= '0;
      IO_OE_O <= 1'b0;
    end else begin
      pins_r.ce_n <= state_r == nand_host_pkg::S_IDLE;
      pins_r.cle  <= kind == nand_host_pkg::K_CMD || kind == nand_host_pkg::K_P70 ||
                     kind == nand_host_pkg::K_P00;
      pins_r.ale  <= kind == nand_host_pkg::K_ADDR;
      pins_r.we_n <= !(state_r == nand_host_pkg::S_LOW && kind inside {nand_host_pkg::K_CMD,
                     nand_host_pkg::K_ADDR, nand_host_pkg::K_WR, nand_host_pkg::K_P70,
                     nand_host_pkg::K_P00});
      pins_r.re_n <= !(state_r == nand_host_pkg::S_LOW && kind inside {nand_host_pkg::K_RD,
                     nand_host_pkg::K_STAT, nand_host_pkg::K_PST});
      IO_OE_O     <= kind inside {nand_host_pkg::K_CMD, nand_host_pkg::K_ADDR,
                     nand_host_pkg::K_WR, nand_host_pkg::K_P70, nand_host_pkg::K_P00} &&
                     state_r inside {nand_host_pkg::S_LOW, nand_host_pkg::S_HIGH};
      unique case (kind)
        nand_host_pkg::K_P70: IO_O <= IO_W'(`CMD_STATUS);
        nand_host_pkg::K_P00: IO_O <= IO_W'(`CMD_READ_MODE);
        // Reserved P2-P4 always go out as zero
        nand_host_pkg::K_WR:  IO_O <= IO_W'(cnt_r == 5'h00 ? p1_eff : 8'h00);
        default:              IO_O <= IO_W'(act.data);
      endcase
    end
  end

  assign CE_N_O = pins_r.ce_n;
  assign CLE_O  = pins_r.cle;
  assign ALE_O  = pins_r.ale;
  assign WE_N_O = pins_r.we_n;
  assign RE_N_O = pins_r.re_n;
endmodule // nand_uid_feat_host
`default_nettype wire

// ==== nand_host_sva.sv ====
// Port-level protocol checks for the NAND host controller
`timescale 1ns/1ps
`default_nettype none
module nand_host_sva #(
  parameter int IO_W = 8
) (
  // System and bus
  input wire logic            CLK_I,
  input wire logic            RST_I,
  input wire logic            STB_I,
  input wire logic            CYC_I,
  input wire logic            ACK_O,
  // NAND pins
  input wire logic            CE_N_O,
  input wire logic            CLE_O,
  input wire logic            ALE_O,
  input wire logic            WE_N_O,
  input wire logic            RE_N_O,
  input wire logic [IO_W-1:0] IO_O,
  input wire logic            IO_OE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_ack_one_cycle: assert property (ACK_O |=> !ACK_O)
    else $error("ack held longer than one cycle");
  a_ack_two_edges: assert property ($rose(CYC_I & STB_I) |-> !ACK_O ##[2:3] ACK_O)
    else $error("ack latency wrong");
  a_ack_needs_req: assert property (ACK_O |-> $past(CYC_I & STB_I))
    else $error("ack without request");
  a_we_low_hold: assert property ($fell(WE_N_O) |-> (!WE_N_O)[*5])
    else $error("write strobe too short");
  a_strobe_excl: assert property (!(!WE_N_O && !RE_N_O))
    else $error("both strobes low");
  a_latch_excl: assert property (!(CLE_O && ALE_O))
    else $error("command and address latch together");
  a_drive_on_we: assert property (!WE_N_O |-> IO_OE_O)
    else $error("write strobe without driven bus");
  a_release_on_re: assert property (!RE_N_O |-> !IO_OE_O)
    else $error("bus driven during read strobe");
  a_io_steady: assert property (!WE_N_O && $past(!WE_N_O) |-> $stable(IO_O))
    else $error("data moved inside write strobe");
  a_ce_on_strobe: assert property ((!WE_N_O || !RE_N_O) |-> !CE_N_O)
    else $error("strobe with chip deselected");

  c_cmd_cycle: cover property ($fell(WE_N_O) && CLE_O);
  c_read_cycle: cover property ($fell(RE_N_O));
  c_bus_ack: cover property (ACK_O);
endmodule // nand_host_sva

bind nand_uid_feat_host nand_host_sva #(.IO_W(IO_W)) u_sva (
  .CLK_I(CLK_I), .RST_I(RST_I), .STB_I(STB_I), .CYC_I(CYC_I), .ACK_O(ACK_O),
  .CE_N_O(CE_N_O), .CLE_O(CLE_O), .ALE_O(ALE_O), .WE_N_O(WE_N_O), .RE_N_O(RE_N_O),
  .IO_O(IO_O), .IO_OE_O(IO_OE_O));
`default_nettype wire

// ==== nand_dev_model.sv ====
// Behavioural NAND target for unique-ID and feature commands
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model (
  // Host side
  input  wire logic       ce_n_i,
  input  wire logic       cle_i,
  input  wire logic       ale_i,
  input  wire logic       we_n_i,
  input  wire logic       re_n_i,
  input  wire logic [7:0] io_i,
  // Device answers
  output logic      [7:0] io_o,
  output logic            rb_o
);
  logic [7:0] cmd_r, fa_r, stat_r;
  logic [7:0] feat_r [256][4];
  logic       smode_r;
  int         col_r, np_r, locks_r;

  // Copy 0 carries one broken byte so the host must move on
  function automatic logic [7:0] uid(input int i);
    logic [7:0] b;
    b = 8'((i / 32) * 16 + i % 16) ^ 8'h5a;
    if (i == 3) return b ^ 8'h01;
    return (i % 32 < 16) ? b : ~b;
  endfunction

  task automatic go_busy(input int ns);
    fork
      begin
        rb_o = 1'b0;
        #ns;
        rb_o = 1'b1;
      end
    join_none
  endtask

  initial begin
    rb_o = 1'b1;
    io_o = 8'h00;
    stat_r = 8'h40;
    smode_r = 1'b0;
    foreach (feat_r[a, b]) feat_r[a][b] = 8'h00;
  end

  always @(posedge we_n_i) begin
    if (!ce_n_i && cle_i) begin
      cmd_r = io_i;
      np_r = 0;
      smode_r = (io_i == 8'h70);
      if (io_i != 8'h70) stat_r = 8'h40;
    end else if (!ce_n_i && ale_i) begin
      if (cmd_r == 8'h05) begin
        col_r = (np_r == 0) ? int'(io_i) : col_r + 256 * int'(io_i);
        np_r++;
      end else begin
        fa_r = io_i;
        col_r = 0;
        if (cmd_r != 8'hef) go_busy(200);
      end
    end else if (!ce_n_i && cmd_r == 8'hef && np_r < 4) begin
      feat_r[fa_r][np_r] = io_i;
      np_r++;
      if (np_r == 4) begin
        if (fa_r == 8'h90 && feat_r[fa_r][0] == 8'h10) begin
          if (locks_r > 0) stat_r = 8'h60;
          locks_r++;
        end
        // Timing mode change holds busy longer than an ordinary set
        go_busy(fa_r == 8'h01 ? 600 : 200);
      end
    end
  end

  always @(negedge re_n_i) begin
    if (!ce_n_i) begin
      if (smode_r) io_o = {stat_r[7], rb_o, stat_r[5:0]};
      else if (cmd_r == 8'hee) io_o = feat_r[fa_r][col_r % 4];
      else io_o = uid(col_r);
      col_r++;
    end
  end

  // Released bus must not keep showing the last byte
  always @(posedge re_n_i) io_o = ~io_o;
endmodule // nand_dev_model
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the NAND unique-ID and feature host controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk, rst, we, stb, cyc, ack, ce_n, cle, ale, we_n, re_n, oe, rb;
  logic [7:0]  adr, io_d, io_dev;
  logic [15:0] io_h;
  logic [31:0] dat, dat_o, seed_r;
  logic [3:0]  sel;
  int          miscompares, samples_checked;

  assign io_d = oe ? io_h[7:0] : io_dev;

  // Wide bus: upper lines carry junk the host must ignore
  nand_uid_feat_host #(.IO_W(16), .ECC_FIXED(1'b0)) dut (
    .CLK_I(clk), .RST_I(rst), .ADR_I(adr), .DAT_I(dat), .SEL_I(sel), .WE_I(we),
    .STB_I(stb), .CYC_I(cyc), .DAT_O(dat_o), .ACK_O(ack), .CE_N_O(ce_n), .CLE_O(cle),
    .ALE_O(ale), .WE_N_O(we_n), .RE_N_O(re_n), .IO_O(io_h), .IO_OE_O(oe),
    .IO_I({seed_r[15:8], io_d}), .RB_I(rb));
  nand_dev_model u_dev (
    .ce_n_i(ce_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n), .re_n_i(re_n), .io_i(io_d),
    .io_o(io_dev), .rb_o(rb));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic int uid_exp(input int i);
    int b;
    b = ((i / 32) * 16 + i % 16) ^ 'h5a;
    if (i == 3) return b ^ 1;
    return (i % 32 < 16) ? b : b ^ 'hff;
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk);
    adr <= a;
    we <= w;
    dat <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 40) cmp(32'h1, 32'h0);
  endtask

  // Refused starts never raise done, so stop on either flag
  task automatic run(input logic [31:0] ctrl, output logic [31:0] st);
    int n;
    wb(8'h00, 1'b1, ctrl, st);
    n = 0;
    do begin
      wb(8'h10, 1'b0, 32'h0, st);
      n++;
    end while (st[1] !== 1'b1 && st[3] !== 1'b1 && n < 600);
    if (n >= 600) cmp(32'h1, 32'h0);
  endtask

  task automatic set_feat(input logic [7:0] a, input logic [7:0] p1, output logic [31:0] st);
    wb(8'h04, 1'b1, 32'(a), st);
    wb(8'h08, 1'b1, 32'(p1), st);
    run(32'h2, st);
  endtask

  task automatic get_feat(input logic [7:0] a, output logic [31:0] q);
    wb(8'h04, 1'b1, 32'(a), q);
    run(32'h3, q);
    wb(8'h14, 1'b0, 32'h0, q);
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #200000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    logic [31:0] q;
    logic [7:0]  p;
    logic [7:0]  fa [4];
    rst = 1'b1;
    {we, stb, cyc} = 3'b000;
    adr = 8'h00;
    dat = 32'h0;
    sel = 4'hf;
    seed_r = 32'h366a;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wb(8'h40, 1'b0, 32'h0, q);
    cmp(q, 32'h0);
    run(32'h4, q);
    cmp(32'(q[15:8]), 32'h40);
    $display("status test done");
    for (int c = 0; c < 2; c++) begin
      wb(8'h0c, 1'b1, 32'(c), q);
      run(32'h1 | 32'(c << 3), q);
      cmp(32'(q[2]), 32'(c));
      for (int i = 0; i < 32; i++) begin
        wb(8'h80 + 8'(4 * i), 1'b0, 32'h0, q);
        cmp(q & 32'hff, 32'(uid_exp(c * 32 + i)));
      end
    end
    $display("unique id test done");
    fa = '{8'h01, 8'h80, 8'h81, 8'h90};
    foreach (fa[k]) begin
      seed_r <= lfsr(seed_r);
      p = (k == 0) ? 8'(lfsr(seed_r) % 6) : (k == 3) ? 8'h08 : 8'(lfsr(seed_r) & 32'h3);
      get_feat(fa[k], q);
      cmp(q, 32'h0);
      set_feat(fa[k], p, q);
      cmp(q & 32'hff0b, 32'h4002);
      get_feat(fa[k], q);
      cmp(q, 32'(p));
    end
    $display("feature test done");
    for (int r = 0; r < 2; r++) begin
      set_feat(8'h90, 8'h10, q);
      cmp(32'(q[15:8]), (r == 1) ? 32'h60 : 32'h40);
    end
    set_feat(8'h02, 8'h00, q);
    cmp(32'(q[3]), 32'h1);
    set_feat(8'h01, 8'h06, q);
    cmp(32'(q[3]), 32'h1);
    $display("lock and refusal test done");
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
